/* rtl/cbe_core.sv */
// Conditional branch evaluator with a Wishbone register file.
// Overview of operation
// - signed above taken when (pv^s)|z is 0
// - signed at-least taken when pv^s is 0
// - signed below taken when pv^s is 1
// - signed at-most taken when (pv^s)|z is 1
// - unsigned above taken when z|carry is 0
// - unsigned at-most taken when z|carry is 1
// - not taken: nothing changes, fall through
// - bit set branch taken on bit 1
// - bit clear branch taken on bit 0
// - test-and-clear branches then zeroes set bit
// - target is next address plus signed offset
// - operands saddr, sfr, A, X, PSW halves
// - clearing a status_word_low bit clears flag
// Assumes a classic Wishbone master and synchronous inputs on clk_i.
// Results and operands hold until software or a GO changes them.
//
// Register access over Wishbone and the register offsets were left to the implementer.
`timescale 1ns/10ps
module cbe_core (
    input wire logic clk_i,                          // Core clock
    input wire logic rst_i,                          // Synchronous reset, high
    input wire logic wb_cyc_i,                       // Bus cycle
    input wire logic wb_stb_i,                       // Bus strobe
    input wire logic wb_we_i,                        // Write enable
    input wire logic [cbe_pkg::ADR_W-1:0] wb_adr_i,  // Byte address
    input wire logic [3:0] wb_sel_i,                 // Byte lanes
    input wire logic [31:0] wb_dat_i,                // Write data
    output logic [31:0] wb_dat_o,                    // Read data
    output logic wb_ack_o,                           // Acknowledge
    output logic taken_o,                            // Last branch taken
    output logic [15:0] target_o,                    // Last branch target
    output logic [15:0] next_pc_o,                   // Address executed next
    output logic done_o                              // Evaluation done pulse
);

    // =========================================================
    // State
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_EXEC = 2'b10
    } cbe_fsm_t;

    typedef struct packed {
        cbe_fsm_t state;
        logic ack;
        logic [31:0] rdata;
        logic [3:0] op;
        logic [2:0] space;
        logic [2:0] bit_idx;
        logic [7:0] saddr_off;
        logic [15:0] pc;
        logic [7:0] disp;
        logic [7:0] swlo;
        logic [7:0] swhi;
        logic [7:0] acc;
        logic [7:0] xreg;
        logic [7:0] sfr;
        logic valid;
        logic taken;
        logic done;
        logic [15:0] target;
        logic [15:0] next_pc;
        logic [cbe_pkg::SADDR_DEPTH-1:0][7:0] mem;
    } cbe_state_t;

    cbe_state_t q;
    cbe_state_t d;

    // =========================================================
    // Helpers
    function automatic logic [31:0] lane_mask(input logic [3:0] sel);
        lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    endfunction

    // Unselected lanes keep their old value
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat,
                                          input logic [3:0] sel);
        merge = (old & ~lane_mask(sel)) | (dat & lane_mask(sel));
    endfunction

    // Byte-wide operand write keeps only the bytes selected
    function automatic logic [7:0] merge_byte(input logic [7:0] old, input logic [31:0] dat,
                                              input logic [3:0] sel);
        logic [31:0] m;
        m = merge({24'h000000, old}, dat, sel);
        merge_byte = m[7:0];
    endfunction

    // Bit tests on sfr, and on saddr except the set test, are four bytes; compares and all other forms are three
    function automatic logic [2:0] instr_len(input logic [3:0] op, input logic [2:0] space);
        logic bit_op;
        bit_op = (op >= cbe_pkg::OP_BIT_SET);
        if (!bit_op)
        begin
            instr_len = cbe_pkg::LEN_SHORT;
        end
        else if (space == cbe_pkg::SP_SFR)
        begin
            instr_len = cbe_pkg::LEN_LONG;
        end
        else if (space == cbe_pkg::SP_SADDR && op != cbe_pkg::OP_BIT_SET)
        begin
            instr_len = cbe_pkg::LEN_LONG;
        end
        else
        begin
            instr_len = cbe_pkg::LEN_SHORT;
        end
    endfunction

    // Write-back value of the test-and-clear form
    function automatic logic [7:0] clear_bit(input logic [7:0] val, input logic [2:0] idx);
        clear_bit = val & ~(8'h01 << idx);
    endfunction

    // =========================================================
    // Operand fetch and arithmetic
    logic [7:0] operand;
    logic opnd_bit;
    logic cond_met;
    logic [2:0] len;
    logic [15:0] target;
    logic [15:0] fall;
    logic [15:0] saddr_abs;

    // Operand mux is shared by the bit test and the clear write-back
    always_comb
    begin
        saddr_abs = 16'(cbe_pkg::SADDR_BASE + {8'h00, q.saddr_off});
        case (q.space)
            cbe_pkg::SP_SADDR: operand = q.mem[q.saddr_off];
            cbe_pkg::SP_SFR: operand = q.sfr;
            cbe_pkg::SP_ACC: operand = q.acc;
            cbe_pkg::SP_XREG: operand = q.xreg;
            cbe_pkg::SP_SWHI: operand = q.swhi;
            cbe_pkg::SP_SWLO: operand = q.swlo;
            default: operand = cbe_pkg::RST_BYTE;
        endcase
        opnd_bit = operand[q.bit_idx];
        len = instr_len(q.op, q.space);
    end

    // Decision and arithmetic kept apart so each can be checked alone
    cbe_cond_eval u_cond (
        .op_i(q.op),
        .flags_i(q.swlo),
        .bit_i(opnd_bit),
        .taken_o(cond_met)
    );

    // Target is formed every cycle; only the exec cycle latches it
    cbe_target_calc u_tgt (
        .pc_i(q.pc),
        .len_i(len),
        .disp_i(q.disp),
        .target_o(target),
        .fall_o(fall)
    );

    // =========================================================
    // Field bounds of the control and status words
    localparam int unsigned CTRL_OP_HI = cbe_pkg::CTRL_OP_LSB + 3;
    localparam int unsigned CTRL_SP_HI = cbe_pkg::CTRL_SPACE_LSB + 2;
    localparam int unsigned CTRL_BIT_HI = cbe_pkg::CTRL_BIT_LSB + 2;
    localparam int unsigned CTRL_SA_HI = cbe_pkg::CTRL_SADDR_LSB + 7;
    localparam int unsigned STAT_TGT_HI = cbe_pkg::STAT_TARGET_LSB + 15;

    // =========================================================
    // Next state
    logic req;
    logic [31:0] ctrl_rd;
    logic [31:0] ctrl_wr;
    logic [31:0] stat_rd;
    logic [31:0] pc_wr;
    logic [7:0] cleared;

    always_comb
    begin
        d = q;
        d.done = 1'b0;
        req = wb_cyc_i & wb_stb_i;
        cleared = clear_bit(operand, q.bit_idx);
        ctrl_rd = 32'h00000000;
        ctrl_rd[CTRL_OP_HI:cbe_pkg::CTRL_OP_LSB] = q.op;
        ctrl_rd[CTRL_SP_HI:cbe_pkg::CTRL_SPACE_LSB] = q.space;
        ctrl_rd[CTRL_BIT_HI:cbe_pkg::CTRL_BIT_LSB] = q.bit_idx;
        ctrl_rd[CTRL_SA_HI:cbe_pkg::CTRL_SADDR_LSB] = q.saddr_off;
        ctrl_wr = merge(ctrl_rd, wb_dat_i, wb_sel_i);
        pc_wr = merge({16'h0000, q.pc}, wb_dat_i, wb_sel_i);

        // Busy is high only in the one evaluation cycle, when no read is served, so it always reads 0
        stat_rd = 32'h00000000;
        stat_rd[cbe_pkg::STAT_VALID_BIT] = q.valid;
        stat_rd[cbe_pkg::STAT_TAKEN_BIT] = q.taken;
        stat_rd[cbe_pkg::STAT_BUSY_BIT] = (q.state == ST_EXEC);
        stat_rd[STAT_TGT_HI:cbe_pkg::STAT_TARGET_LSB] = q.target;

        case (q.state)
            ST_IDLE:
            begin
                // Ack one cycle after the strobe, then drop for a cycle
                if (q.ack)
                begin
                    d.ack = 1'b0;
                end
                else if (req)
                begin
                    d.ack = 1'b1;
                    d.rdata = 32'h00000000;
                    // Short direct area: one byte a word, upper bytes read 0
                    if (wb_adr_i[11:10] == cbe_pkg::WIN_SADDR)
                    begin
                        if (wb_we_i)
                        begin
                            d.mem[wb_adr_i[9:2]] = merge_byte(q.mem[wb_adr_i[9:2]],
                                                              wb_dat_i, wb_sel_i);
                        end
                        else
                        begin
                            d.rdata = {24'h000000, q.mem[wb_adr_i[9:2]]};
                        end
                    end
                    else if (wb_we_i)
                    begin
                        case ({wb_adr_i[11:2], 2'b00})
                            cbe_pkg::OFF_CTRL:
                            begin
                                d.op = ctrl_wr[CTRL_OP_HI:cbe_pkg::CTRL_OP_LSB];
                                d.space = ctrl_wr[CTRL_SP_HI:cbe_pkg::CTRL_SPACE_LSB];
                                d.bit_idx = ctrl_wr[CTRL_BIT_HI:cbe_pkg::CTRL_BIT_LSB];
                                d.saddr_off = ctrl_wr[CTRL_SA_HI:cbe_pkg::CTRL_SADDR_LSB];
                                if (wb_sel_i[3] && wb_dat_i[cbe_pkg::CTRL_GO_BIT])
                                begin
                                    d.state = ST_EXEC;
                                    d.valid = 1'b0;
                                end
                            end
                            cbe_pkg::OFF_PC:
                            begin
                                d.pc = pc_wr[15:0];
                            end
                            cbe_pkg::OFF_DISP: d.disp = merge_byte(q.disp, wb_dat_i, wb_sel_i);
                            cbe_pkg::OFF_SWLO: d.swlo = merge_byte(q.swlo, wb_dat_i, wb_sel_i);
                            cbe_pkg::OFF_SWHI: d.swhi = merge_byte(q.swhi, wb_dat_i, wb_sel_i);
                            cbe_pkg::OFF_ACC: d.acc = merge_byte(q.acc, wb_dat_i, wb_sel_i);
                            cbe_pkg::OFF_XREG: d.xreg = merge_byte(q.xreg, wb_dat_i, wb_sel_i);
                            cbe_pkg::OFF_SFR: d.sfr = merge_byte(q.sfr, wb_dat_i, wb_sel_i);
                            default:
                            begin
                                d.rdata = 32'h00000000;
                            end
                        endcase
                    end
                    else
                    begin
                        case ({wb_adr_i[11:2], 2'b00})
                            cbe_pkg::OFF_CTRL: d.rdata = ctrl_rd;
                            cbe_pkg::OFF_PC: d.rdata = {16'h0000, q.pc};
                            cbe_pkg::OFF_DISP: d.rdata = {24'h000000, q.disp};
                            cbe_pkg::OFF_SWLO: d.rdata = {24'h000000, q.swlo};
                            cbe_pkg::OFF_SWHI: d.rdata = {24'h000000, q.swhi};
                            cbe_pkg::OFF_ACC: d.rdata = {24'h000000, q.acc};
                            cbe_pkg::OFF_XREG: d.rdata = {24'h000000, q.xreg};
                            cbe_pkg::OFF_SFR: d.rdata = {24'h000000, q.sfr};
                            cbe_pkg::OFF_STATUS: d.rdata = stat_rd;
                            cbe_pkg::OFF_NEXT_PC: d.rdata = {16'h0000, q.next_pc};
                            default: d.rdata = 32'h00000000;
                        endcase
                    end
                end
            end
            ST_EXEC:
            begin
                // Bus is held off for this one cycle so no write races the result
                d.ack = 1'b0;
                d.state = ST_IDLE;
                d.done = 1'b1;
                d.valid = 1'b1;
                d.taken = cond_met;
                d.target = target;
                d.next_pc = cond_met ? target : fall;
                // Only the taken test-and-clear writes back; flags stay otherwise
                if (q.op == cbe_pkg::OP_BIT_SET_THEN_ZERO && cond_met)
                begin
                    case (q.space)
                        cbe_pkg::SP_SADDR: d.mem[q.saddr_off] = cleared;
                        cbe_pkg::SP_SFR: d.sfr = cleared;
                        cbe_pkg::SP_ACC: d.acc = cleared;
                        cbe_pkg::SP_XREG: d.xreg = cleared;
                        cbe_pkg::SP_SWHI: d.swhi = cleared;
                        cbe_pkg::SP_SWLO: d.swlo = cleared;
                        default: d.swlo = q.swlo;
                    endcase
                end
            end
            default:
            begin
                d.state = ST_IDLE;
                d.ack = 1'b0;
            end
        endcase
    end

    // =========================================================
    // Registers
    // Sync reset clears the operand array too, at a wide fan-out cost
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            q <= '0;
            q.state <= ST_IDLE;
            q.pc <= cbe_pkg::RST_WORD;
            q.swlo <= cbe_pkg::RST_BYTE;
        end
        else
        begin
            q <= d;
        end
    end

    // =========================================================
    // Outputs, all straight from flip-flops
    always_comb
    begin
        wb_dat_o = q.rdata;
        wb_ack_o = q.ack;
        taken_o = q.taken;
        target_o = q.target;
        next_pc_o = q.next_pc;
        done_o = q.done;
    end

    // saddr_abs documents the reachable window for debug views only
    logic unused_abs;
    always_comb
    begin
        unused_abs = ^saddr_abs;
    end

endmodule

/* rtl/cbe_pkg.sv */
// Constants shared by the conditional branch evaluator and its leaf modules.
// Assumes a 32-bit classic Wishbone slave port with byte addresses.
package cbe_pkg;

    // =========================================================
    // Bus geometry
    localparam int unsigned ADR_W = 12;
    localparam logic [11:0] OFF_CTRL = 12'h000;
    localparam logic [11:0] OFF_PC = 12'h004;
    localparam logic [11:0] OFF_DISP = 12'h008;
    localparam logic [11:0] OFF_SWLO = 12'h00c;
    localparam logic [11:0] OFF_SWHI = 12'h010;
    localparam logic [11:0] OFF_ACC = 12'h014;
    localparam logic [11:0] OFF_XREG = 12'h018;
    localparam logic [11:0] OFF_SFR = 12'h01c;
    localparam logic [11:0] OFF_STATUS = 12'h020;
    localparam logic [11:0] OFF_NEXT_PC = 12'h024;
    localparam logic [1:0] WIN_SADDR = 2'h1;

    // =========================================================
    // Control and status register fields
    localparam int unsigned CTRL_OP_LSB = 0;
    localparam int unsigned CTRL_SPACE_LSB = 4;
    localparam int unsigned CTRL_BIT_LSB = 8;
    localparam int unsigned CTRL_SADDR_LSB = 16;
    localparam int unsigned CTRL_GO_BIT = 31;
    localparam int unsigned STAT_VALID_BIT = 0;
    localparam int unsigned STAT_TAKEN_BIT = 1;
    localparam int unsigned STAT_BUSY_BIT = 2;
    localparam int unsigned STAT_TARGET_LSB = 16;

    // =========================================================
    // Flag positions in status_word_low
    localparam int unsigned FLAG_S = 7;
    localparam int unsigned FLAG_Z = 6;
    localparam int unsigned FLAG_AC = 4;
    localparam int unsigned FLAG_PV = 2;
    localparam int unsigned FLAG_CO = 0;

    // =========================================================
    // Reset values and operand geometry
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [15:0] SADDR_BASE = 16'hfe20;
    localparam int unsigned SADDR_DEPTH = 256;
    localparam logic [2:0] LEN_SHORT = 3'h3;
    localparam logic [2:0] LEN_LONG = 3'h4;

    // =========================================================
    // Branch kinds and operand spaces
    typedef enum logic [3:0] {
        OP_SIGNED_ABOVE = 4'h0,
        OP_SIGNED_AT_LEAST = 4'h1,
        OP_SIGNED_BELOW = 4'h2,
        OP_SIGNED_AT_MOST = 4'h3,
        OP_UNSIGNED_ABOVE = 4'h4,
        OP_UNSIGNED_AT_MOST = 4'h5,
        OP_BIT_SET = 4'h6,
        OP_BIT_CLEAR = 4'h7,
        OP_BIT_SET_THEN_ZERO = 4'h8
    } cbe_op_t;

    typedef enum logic [2:0] {
        SP_SADDR = 3'h0,
        SP_SFR = 3'h1,
        SP_ACC = 3'h2,
        SP_XREG = 3'h3,
        SP_SWHI = 3'h4,
        SP_SWLO = 3'h5
    } cbe_space_t;

endpackage

/* rtl/cbe_cond_eval.sv */
// Branch condition decision from flags and the tested operand bit.
// Purely combinational; the caller registers the result.
`timescale 1ns/10ps
module cbe_cond_eval (
    input wire logic [3:0] op_i,     // Branch kind
    input wire logic [7:0] flags_i,  // status_word_low
    input wire logic bit_i,          // Tested operand bit
    output logic taken_o             // Condition met
);
    logic sv;
    logic z;
    logic co;

    always_comb
    begin
        sv = flags_i[cbe_pkg::FLAG_PV] ^ flags_i[cbe_pkg::FLAG_S];
        z = flags_i[cbe_pkg::FLAG_Z];
        co = flags_i[cbe_pkg::FLAG_CO];
        case (op_i)
            cbe_pkg::OP_SIGNED_ABOVE: taken_o = ((sv | z) == 1'b0);
            cbe_pkg::OP_SIGNED_AT_LEAST: taken_o = (sv == 1'b0);
            cbe_pkg::OP_SIGNED_BELOW: taken_o = (sv == 1'b1);
            cbe_pkg::OP_SIGNED_AT_MOST: taken_o = ((sv | z) == 1'b1);
            cbe_pkg::OP_UNSIGNED_ABOVE: taken_o = ((z | co) == 1'b0);
            cbe_pkg::OP_UNSIGNED_AT_MOST: taken_o = ((z | co) == 1'b1);
            cbe_pkg::OP_BIT_SET: taken_o = bit_i;
            cbe_pkg::OP_BIT_CLEAR: taken_o = ~bit_i;
            cbe_pkg::OP_BIT_SET_THEN_ZERO: taken_o = bit_i;
            default: taken_o = 1'b0;
        endcase
    end
endmodule

/* rtl/cbe_target_calc.sv */
// Branch target and fall-through address arithmetic.
// Addresses wrap modulo 64K like the program counter.
`timescale 1ns/10ps
module cbe_target_calc (
    input wire logic [15:0] pc_i,        // Address of the branch
    input wire logic [2:0] len_i,        // Instruction length in bytes
    input wire logic [7:0] disp_i,       // jump_offset_byte, signed
    output logic [15:0] target_o,        // Taken address
    output logic [15:0] fall_o           // Next instruction address
);
    always_comb
    begin
        fall_o = 16'(pc_i + {13'h0000, len_i});
        target_o = 16'(fall_o + {{8{disp_i[7]}}, disp_i});
    end
endmodule

/* sim/cbe_core_monitor.sv */
// Concurrent checks on the bus and result ports of the branch evaluator.
// Bound to cbe_core by the bench; sees only the top module's ports.
`timescale 1ns/10ps
module cbe_core_monitor (
    input wire logic clk_i,                          // Core clock
    input wire logic rst_i,                          // Synchronous reset
    input wire logic wb_cyc_i,                       // Bus cycle
    input wire logic wb_stb_i,                       // Bus strobe
    input wire logic wb_we_i,                        // Write enable
    input wire logic [cbe_pkg::ADR_W-1:0] wb_adr_i,  // Byte address
    input wire logic [3:0] wb_sel_i,                 // Byte lanes
    input wire logic [31:0] wb_dat_i,                // Write data
    input wire logic [31:0] wb_dat_o,                // Read data
    input wire logic wb_ack_o,                       // Acknowledge
    input wire logic taken_o,                        // Last decision
    input wire logic [15:0] target_o,                // Last target
    input wire logic [15:0] next_pc_o,               // Next address
    input wire logic done_o                          // Done pulse
);
    wire logic go_ack = wb_ack_o && wb_we_i && wb_adr_i == cbe_pkg::OFF_CTRL
        && wb_dat_i[cbe_pkg::CTRL_GO_BIT] && wb_sel_i[3];
    wire logic rd_ack = wb_ack_o && !wb_we_i;

    // ==========================================================
    // Properties
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    property p_ack_cyc;
        wb_ack_o |-> wb_cyc_i && wb_stb_i;
    endproperty
    a_ack_cyc: assert property (p_ack_cyc) else $error("ack without a request");
    property p_ack_bound;
        $rose(wb_stb_i) |-> ##[1:3] wb_ack_o;
    endproperty
    a_ack_bound: assert property (p_ack_bound) else $error("no ack within three cycles");
    property p_go_done;
        go_ack |=> done_o;
    endproperty
    a_go_done: assert property (p_go_done) else $error("start without done");
    property p_done_cause;
        done_o |-> $past(go_ack) && !$past(done_o);
    endproperty
    a_done_cause: assert property (p_done_cause) else $error("done without start");
    property p_hold;
        !done_o && !$past(rst_i) |-> $stable(taken_o) && $stable(target_o) && $stable(next_pc_o);
    endproperty
    a_hold: assert property (p_hold) else $error("result moved without done");
    property p_taken_next;
        done_o && taken_o |-> next_pc_o == target_o;
    endproperty
    a_taken_next: assert property (p_taken_next) else $error("taken but next differs");
    property p_status_rd;
        rd_ack && wb_adr_i == cbe_pkg::OFF_STATUS |->
            wb_dat_o[cbe_pkg::STAT_TAKEN_BIT] == taken_o && wb_dat_o[31:16] == target_o;
    endproperty
    a_status_rd: assert property (p_status_rd) else $error("status read disagrees");
    property p_next_rd;
        rd_ack && wb_adr_i == cbe_pkg::OFF_NEXT_PC |-> wb_dat_o == {16'h0, next_pc_o};
    endproperty
    a_next_rd: assert property (p_next_rd) else $error("next address read disagrees");
endmodule

/* sim/tb.sv */
// Self-checking bench for the conditional branch evaluator.
// Acts as the Wishbone master itself; the port monitor is bound at the foot.
`timescale 1ns/10ps
module tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [cbe_pkg::ADR_W-1:0] wb_adr_i = 12'h000;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic taken_o;
    logic [15:0] target_o;
    logic [15:0] next_pc_o;
    logic done_o;
    int fails = 0;
    int total_checks = 0;
    int cycles = 0;

    cbe_core cbe_core_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .taken_o(taken_o),
        .target_o(target_o), .next_pc_o(next_pc_o), .done_o(done_o));

    always #12.5 clk_i = ~clk_i;

    // Whole run is a few thousand cycles; this only cuts a hang
    always @(posedge clk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            fails = fails + 1;
            close_out();
        end
    end

    // ==========================================================
    // Shared tasks
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // Request held until ack is sampled high, then released
    task automatic bus(input logic we, input logic [11:0] adr, input logic [31:0] dat,
                       output logic [31:0] rd);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        wb_sel_i <= 4'hf;
        do
        begin
            @(posedge clk_i);
        end
        while (wb_ack_o !== 1'b1);
        check(32'(wb_ack_o), 32'h1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] adr, input logic [31:0] dat);
        logic [31:0] d;
        bus(1'b1, adr, dat, d);
    endtask

    task automatic rd_chk(input logic [11:0] adr, input logic [31:0] exp);
        logic [31:0] d;
        bus(1'b0, adr, 32'h0, d);
        check(d, exp);
    endtask

    // Loads pc and offset, starts one evaluation and judges all results
    task automatic go(input logic [3:0] op, input logic [2:0] sp, input logic [2:0] bix,
                      input logic [15:0] pc, input logic [7:0] dp, input logic [2:0] len,
                      input logic tk);
        logic [15:0] tgt;
        int n;
        tgt = pc + 16'(len) + {{8{dp[7]}}, dp};
        n = 0;
        wr(cbe_pkg::OFF_PC, 32'(pc));
        wr(cbe_pkg::OFF_DISP, 32'(dp));
        wr(cbe_pkg::OFF_CTRL, {1'b1, 7'h0, 8'hff, 5'h0, bix, 1'b0, sp, op});
        while (done_o !== 1'b1 && n < 8)
        begin
            @(negedge clk_i);
            n++;
        end
        check(32'(done_o), 32'h1);
        check(32'(taken_o), 32'(tk));
        check(32'(target_o), 32'(tgt));
        check(32'(next_pc_o), 32'(tk ? tgt : pc + 16'(len)));
        rd_chk(cbe_pkg::OFF_STATUS, {tgt, 13'h0, 1'b0, tk, 1'b1});
    endtask

    // ==========================================================
    // Scenarios
    task automatic test_map();
        rd_chk(cbe_pkg::OFF_STATUS, 32'h0);
        rd_chk(cbe_pkg::OFF_NEXT_PC, 32'h0);
        wr(12'h300, 32'hffffffff);
        rd_chk(12'h300, 32'h0);
        wr(cbe_pkg::OFF_ACC, 32'h000000a5);
        rd_chk(cbe_pkg::OFF_ACC, 32'h000000a5);
        rd_chk(cbe_pkg::OFF_CTRL, 32'h0);
    endtask

    // Every flag mix for every compare kind; offsets at both extremes, pc wraps
    task automatic test_compare();
        logic [7:0] psw;
        logic x;
        logic tk;
        for (int op = 0; op < 6; op++)
        begin
            for (int i = 0; i < 16; i++)
            begin
                psw = {i[3], i[2], 2'h1, 1'b0, i[1], 1'b0, i[0]};
                x = i[1] ^ i[3];
                case (op)
                    0: tk = !(x | i[2]);
                    1: tk = !x;
                    2: tk = x;
                    3: tk = x | i[2];
                    4: tk = !(i[2] | i[0]);
                    default: tk = i[2] | i[0];
                endcase
                wr(cbe_pkg::OFF_SWLO, 32'(psw));
                go(4'(op), 3'h0, 3'h0, {i[3:0], 12'hff0}, i[0] ? 8'h7f : 8'h80,
                   cbe_pkg::LEN_SHORT, tk);
                rd_chk(cbe_pkg::OFF_SWLO, 32'(psw));
            end
        end
    endtask

    // All bit-test kinds on every operand space, bit both set and clear
    task automatic test_bits();
        logic [11:0] adr;
        logic [7:0] v;
        logic [2:0] len;
        logic [2:0] bix;
        logic tk;
        for (int op = 6; op < 9; op++)
        begin
            for (int k = 0; k < 12; k++)
            begin
                bix = 3'(k / 2 + op + 1);
                v = k[0] ? (8'h5a | (8'h1 << bix)) : (8'h5a & ~(8'h1 << bix));
                case (k / 2)
                    0: adr = 12'h7fc;
                    1: adr = cbe_pkg::OFF_SFR;
                    2: adr = cbe_pkg::OFF_ACC;
                    3: adr = cbe_pkg::OFF_XREG;
                    4: adr = cbe_pkg::OFF_SWHI;
                    default: adr = cbe_pkg::OFF_SWLO;
                endcase
                len = (k / 2 == 1 || (k / 2 == 0 && op != 6)) ? 3'h4 : 3'h3;
                tk = (op == 7) ? !k[0] : k[0];
                wr(adr, 32'(v));
                go(4'(op), 3'(k / 2), bix, 16'h0100, 8'h83, len, tk);
                rd_chk(adr, 32'((op == 8 && k[0]) ? v & ~(8'h1 << bix) : v));
            end
        end
    endtask

    initial
    begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        test_map();
        test_compare();
        test_bits();
        close_out();
    end
endmodule

bind cbe_core cbe_core_monitor cbe_core_monitor_inst (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .taken_o(taken_o), .target_o(target_o), .next_pc_o(next_pc_o), .done_o(done_o));
